// File: src/ssob_pkg.sv
package ssob_pkg;
	// ------------------------------------------------------------
	// Sizes and positions
	// ------------------------------------------------------------
	localparam int ADDR_W = 32;
	localparam int DATA_W = 64;
	localparam int MASK_W = 8;
	localparam int INSTR_W = 32;
	localparam int DW_LSB = 3;
	localparam int WORD_SEL_BIT = 2;
	localparam int SB_DEPTH = 4;
	localparam int SB_IDX_W = 2;
	localparam int SB_CNT_W = 3;
	localparam logic [SB_CNT_W-1:0] SB_FULL = 3'h4;
	localparam int EPOCH_W = 3;
	localparam int IB_LINES = 8;
	localparam int IB_IDX_W = 3;
	localparam int IB_TAG_W = ADDR_W - DW_LSB - IB_IDX_W;
	localparam int RFQ_DEPTH = 4;
	localparam int RFQ_PTR_W = 2;
	localparam int RFQ_CNT_W = 3;
	localparam logic [RFQ_CNT_W-1:0] RFQ_FULL = 3'h4;
	localparam int LFLUSH_MAX_INSTR = 5;
	localparam logic MODE_RST = 1'b0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_LOAD, OP_STORE, OP_FLUSH, OP_ATOMIC, OP_BARRIER, OP_MODE
	} ssob_op_e;
	typedef enum logic [2:0] {
		MK_READ, MK_WRITE, MK_ATOMIC, MK_RFLUSH, MK_IFETCH
	} ssob_mem_e;
	typedef enum logic [1:0] {MS_IDLE, MS_REQ, MS_WAIT} ssob_mst_e;
	typedef enum logic [1:0] {SRC_LOAD, SRC_IFETCH, SRC_DRAIN} ssob_src_e;
	typedef enum logic [1:0] {FS_IDLE, FS_LOOK, FS_MISS} ssob_fst_e;

	typedef struct packed {
		logic valid;
		ssob_op_e op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [MASK_W-1:0] mask;
		logic [EPOCH_W-1:0] epoch;
	} ssob_sbe_s;

	typedef struct packed {
		ssob_sbe_s [SB_DEPTH-1:0] sb;
		logic [SB_CNT_W-1:0] sb_cnt;
		logic mode;
		logic [EPOCH_W-1:0] epoch;
		logic epoch_used;
		logic ld_pend;
		logic [ADDR_W-1:0] ld_addr;
		logic atom;
		logic req_ready;
		logic rsp_valid;
		logic [DATA_W-1:0] rsp_data;
		ssob_mst_e mst;
		ssob_src_e msrc;
		logic mvalid;
		ssob_mem_e mkind;
		logic [ADDR_W-1:0] maddr;
		logic [DATA_W-1:0] mdata;
		logic [MASK_W-1:0] mmask;
		logic [SB_IDX_W-1:0] midx;
		ssob_fst_e fst;
		logic [ADDR_W-1:0] faddr;
		logic fetch_ready;
		logic f_rsp_valid;
		logic [INSTR_W-1:0] f_rsp_data;
		logic lfl_valid;
		logic [ADDR_W-1:0] lfl_addr;
		logic [RFQ_DEPTH-1:0][ADDR_W-1:0] rfq;
		logic [RFQ_PTR_W-1:0] rfq_wp;
		logic [RFQ_PTR_W-1:0] rfq_rp;
		logic [RFQ_CNT_W-1:0] rfq_cnt;
		logic rfl_ready;
	} ssob_state_s;

	typedef struct packed {
		logic [IB_LINES-1:0] vld;
		logic [IB_LINES-1:0][IB_TAG_W-1:0] tag;
		logic [IB_LINES-1:0][DATA_W-1:0] data;
		logic hit;
		logic [INSTR_W-1:0] rdata;
	} ssob_ib_s;

	localparam ssob_state_s ST_RST = '0;
	localparam ssob_ib_s IB_RST = '0;
endpackage

// File: src/ssob_instruction_buffer_if.sv
interface ssob_instruction_buffer_if;
	import ssob_pkg::*;
	logic look_valid;
	logic [ADDR_W-1:0] look_addr;
	logic hit;
	logic [INSTR_W-1:0] rdata;
	logic fill_valid;
	logic [ADDR_W-1:0] fill_addr;
	logic [DATA_W-1:0] fill_data;
	logic inval_valid;
	logic [ADDR_W-1:0] inval_addr;

	modport main (
		output look_valid, look_addr, fill_valid, fill_addr, fill_data,
		output inval_valid, inval_addr,
		input hit, rdata
	);
	modport instruction_buffer (
		input look_valid, look_addr, fill_valid, fill_addr, fill_data,
		input inval_valid, inval_addr,
		output hit, rdata
	);
endinterface

// File: src/ssob_instruction_buffer.sv
module ssob_instruction_buffer
	import ssob_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	ssob_instruction_buffer_if.instruction_buffer ib
);
	ssob_ib_s s_q;
	ssob_ib_s s_d;
	logic [IB_IDX_W-1:0] l_idx;
	logic [IB_IDX_W-1:0] f_idx;
	logic [IB_IDX_W-1:0] i_idx;

	assign l_idx = ib.look_addr[DW_LSB+IB_IDX_W-1:DW_LSB];
	assign f_idx = ib.fill_addr[DW_LSB+IB_IDX_W-1:DW_LSB];
	assign i_idx = ib.inval_addr[DW_LSB+IB_IDX_W-1:DW_LSB];
	assign ib.hit = s_q.hit;
	assign ib.rdata = s_q.rdata;

	// ------------------------------------------------------------
	// Lookup, fill, invalidate
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.hit = ib.look_valid && s_q.vld[l_idx] &&
			s_q.tag[l_idx] == ib.look_addr[ADDR_W-1:DW_LSB+IB_IDX_W];
		s_d.rdata = ib.look_addr[WORD_SEL_BIT] ?
			s_q.data[l_idx][DATA_W-1:INSTR_W] :
			s_q.data[l_idx][INSTR_W-1:0];
		if (ib.fill_valid) begin
			s_d.vld[f_idx] = 1'b1;
			s_d.tag[f_idx] = ib.fill_addr[ADDR_W-1:DW_LSB+IB_IDX_W];
			s_d.data[f_idx] = ib.fill_data;
		end
		// Invalidate after fill so a racing refill cannot survive
		if (ib.inval_valid && s_q.vld[i_idx] && s_q.tag[i_idx] ==
			ib.inval_addr[ADDR_W-1:DW_LSB+IB_IDX_W]) begin
			s_d.vld[i_idx] = 1'b0;
		end
		if (ib.inval_valid && ib.fill_valid && f_idx == i_idx &&
			ib.fill_addr[ADDR_W-1:DW_LSB] ==
			ib.inval_addr[ADDR_W-1:DW_LSB]) begin
			s_d.vld[i_idx] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= IB_RST;
		end else begin
			s_q <= s_d;
		end
	end

	AST_IB_INVAL_MISS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ib.inval_valid && !ib.fill_valid ##1 ib.look_valid &&
		ib.look_addr[ADDR_W-1:DW_LSB] == $past(ib.inval_addr[ADDR_W-1:DW_LSB])
		|=> !ib.hit)
		else $error("lookup hit a line invalidated just before");
endmodule // ssob_instruction_buffer

// File: src/ssob_top.sv
// Functional notes
// - Memory operations leave this port one at a time, single global order.
// - Total store order mode drains the store buffer strictly first-in first-out.
// - Loads search the buffer; newest same-location store answers, else memory.
// - No further memory operation accepted while a load is outstanding.
// - Atomic enters buffer, stalls processor, goes to memory once buffer drained.
// - Partial store order may reorder, but never across a store barrier.
// - Partial store order keeps same-location entries in issue order.
// - Mode bit 0 selects total store order, 1 partial store order.
// - Without partial store order support, setting the mode bit is ignored.
// - Store barrier is a no-operation unless partial store order is active.
// - Instruction buffer has local flush stage, line data, remote flush queue.
// - Flush sends local invalidate and buffers remote flush, without stalling.
// - Local flush invalidates within five instructions of the flush.
// - Fetch of flushed address afterwards misses and loads through memory port.
// - Local flushes take effect in issue order.
// - Remote flush drains like a store, changes no memory, reaches others.
// - Remote flush invalidates when it reaches head of the remote queue.
// - Same location means same aligned doubleword address.
module ssob_top
	import ssob_pkg::*;
#(
	parameter logic PSO_SUPPORTED = 1'b1
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cpu_req_valid,
	input wire ssob_op_e cpu_req_op,
	input wire logic [ADDR_W-1:0] cpu_req_addr,
	input wire logic [DATA_W-1:0] cpu_req_data,
	input wire logic [MASK_W-1:0] cpu_req_mask,
	output logic cpu_req_ready,
	output logic cpu_rsp_valid,
	output logic [DATA_W-1:0] cpu_rsp_data,
	output logic mode_pso,
	input wire logic fetch_valid,
	input wire logic [ADDR_W-1:0] fetch_addr,
	output logic fetch_ready,
	output logic fetch_rsp_valid,
	output logic [INSTR_W-1:0] fetch_rsp_data,
	output logic mem_req_valid,
	output ssob_mem_e mem_req_kind,
	output logic [ADDR_W-1:0] mem_req_addr,
	output logic [DATA_W-1:0] mem_req_data,
	output logic [MASK_W-1:0] mem_req_mask,
	input wire logic mem_req_ready,
	input wire logic mem_rsp_valid,
	input wire logic [DATA_W-1:0] mem_rsp_data,
	input wire logic rfl_in_valid,
	input wire logic [ADDR_W-1:0] rfl_in_addr,
	output logic rfl_in_ready
);
	ssob_state_s s_q;
	ssob_state_s s_d;
	ssob_instruction_buffer_if ib ();
	logic acc;
	logic hit;
	logic [SB_IDX_W-1:0] hit_idx;
	logic sel_ok;
	logic [SB_IDX_W-1:0] sel_idx;
	logic iss_drain;

	function automatic logic same_dw(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] b);
		return a[ADDR_W-1:DW_LSB] == b[ADDR_W-1:DW_LSB];
	endfunction

	ssob_instruction_buffer u_instruction_buffer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ib(ib.instruction_buffer)
	);

	// ------------------------------------------------------------
	// Forwarding search and drain selection
	// ------------------------------------------------------------
	always_comb begin
		logic ok;
		ok = 1'b0;
		hit = 1'b0;
		hit_idx = '0;
		sel_ok = 1'b0;
		sel_idx = '0;
		for (int i = 0; i < SB_DEPTH; i++) begin
			// Later index is newer, so the last match wins
			if (s_q.sb[i].valid && s_q.sb[i].op == OP_STORE &&
				same_dw(s_q.sb[i].addr, cpu_req_addr)) begin
				hit = 1'b1;
				hit_idx = SB_IDX_W'(i);
			end
			ok = s_q.sb[i].valid && (s_q.mode || i == 0);
			if (s_q.sb[i].epoch != s_q.sb[0].epoch) begin
				ok = 1'b0;
			end
			if (s_q.sb[i].op == OP_ATOMIC &&
				(i != 0 || s_q.sb_cnt != SB_CNT_W'(1))) begin
				ok = 1'b0;
			end
			for (int j = 0; j < SB_DEPTH; j++) begin
				if (j < i && s_q.sb[j].valid &&
					same_dw(s_q.sb[j].addr, s_q.sb[i].addr)) begin
					ok = 1'b0;
				end
			end
			// Newest eligible entry goes first in partial order
			if (ok) begin
				sel_ok = 1'b1;
				sel_idx = SB_IDX_W'(i);
			end
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rsp_valid = 1'b0;
		s_d.f_rsp_valid = 1'b0;
		acc = cpu_req_valid && s_q.req_ready;
		iss_drain = 1'b0;
		ib.look_valid = fetch_valid && s_q.fst == FS_IDLE;
		ib.look_addr = fetch_addr;
		ib.fill_valid = 1'b0;
		ib.fill_addr = s_q.faddr;
		ib.fill_data = mem_rsp_data;
		ib.inval_valid = 1'b0;
		ib.inval_addr = s_q.lfl_addr;

		// Local flush stage empties every cycle, ahead of remote flushes
		if (s_q.lfl_valid) begin
			ib.inval_valid = 1'b1;
			s_d.lfl_valid = 1'b0;
		end else if (s_q.rfq_cnt != '0) begin
			ib.inval_valid = 1'b1;
			ib.inval_addr = s_q.rfq[s_q.rfq_rp];
			s_d.rfq_rp = s_q.rfq_rp + RFQ_PTR_W'(1);
			s_d.rfq_cnt = s_q.rfq_cnt - RFQ_CNT_W'(1);
		end
		if (rfl_in_valid && s_q.rfl_ready) begin
			s_d.rfq[s_q.rfq_wp] = rfl_in_addr;
			s_d.rfq_wp = s_q.rfq_wp + RFQ_PTR_W'(1);
			s_d.rfq_cnt = s_d.rfq_cnt + RFQ_CNT_W'(1);
		end

		// Instruction fetch
		case (s_q.fst)
			FS_IDLE: begin
				if (fetch_valid) begin
					s_d.faddr = fetch_addr;
					s_d.fst = FS_LOOK;
				end
			end
			FS_LOOK: begin
				if (ib.hit) begin
					s_d.f_rsp_valid = 1'b1;
					s_d.f_rsp_data = ib.rdata;
					s_d.fst = FS_IDLE;
				end else begin
					s_d.fst = FS_MISS;
				end
			end
			FS_MISS: begin
			end
			default: begin
				s_d.fst = FS_IDLE;
			end
		endcase

		// Memory port: one operation in flight
		case (s_q.mst)
			MS_IDLE: begin
				if (s_q.ld_pend) begin
					s_d.msrc = SRC_LOAD;
					s_d.mkind = MK_READ;
					s_d.maddr = s_q.ld_addr;
					s_d.mvalid = 1'b1;
					s_d.mst = MS_REQ;
				end else if (s_q.fst == FS_MISS) begin
					s_d.msrc = SRC_IFETCH;
					s_d.mkind = MK_IFETCH;
					s_d.maddr = s_q.faddr;
					s_d.mvalid = 1'b1;
					s_d.mst = MS_REQ;
				end else if (sel_ok) begin
					iss_drain = 1'b1;
					s_d.msrc = SRC_DRAIN;
					s_d.midx = sel_idx;
					s_d.maddr = s_q.sb[sel_idx].addr;
					s_d.mdata = s_q.sb[sel_idx].data;
					s_d.mmask = s_q.sb[sel_idx].mask;
					case (s_q.sb[sel_idx].op)
						OP_ATOMIC: s_d.mkind = MK_ATOMIC;
						OP_FLUSH: s_d.mkind = MK_RFLUSH;
						default: s_d.mkind = MK_WRITE;
					endcase
					s_d.mvalid = 1'b1;
					s_d.mst = MS_REQ;
				end
			end
			MS_REQ: begin
				if (mem_req_ready) begin
					s_d.mvalid = 1'b0;
					s_d.mst = MS_WAIT;
				end
			end
			MS_WAIT: begin
				if (mem_rsp_valid) begin
					s_d.mst = MS_IDLE;
					case (s_q.msrc)
						SRC_LOAD: begin
							s_d.rsp_valid = 1'b1;
							s_d.rsp_data = mem_rsp_data;
							s_d.ld_pend = 1'b0;
						end
						SRC_IFETCH: begin
							ib.fill_valid = 1'b1;
							s_d.f_rsp_valid = 1'b1;
							s_d.f_rsp_data = s_q.faddr[WORD_SEL_BIT] ?
								mem_rsp_data[DATA_W-1:INSTR_W] :
								mem_rsp_data[INSTR_W-1:0];
							s_d.fst = FS_IDLE;
						end
						default: begin
							if (s_q.sb[s_q.midx].op == OP_ATOMIC) begin
								s_d.rsp_valid = 1'b1;
								s_d.rsp_data = mem_rsp_data;
								s_d.atom = 1'b0;
							end
							for (int i = 0; i < SB_DEPTH - 1; i++) begin
								if (i >= int'(s_q.midx)) begin
									s_d.sb[i] = s_d.sb[i+1];
								end
							end
							s_d.sb[SB_DEPTH-1] = '0;
							s_d.sb_cnt = s_q.sb_cnt - SB_CNT_W'(1);
						end
					endcase
				end
			end
			default: begin
				s_d.mst = MS_IDLE;
			end
		endcase

		// Processor requests
		if (acc) begin
			case (cpu_req_op)
				OP_LOAD: begin
					if (hit) begin
						s_d.rsp_valid = 1'b1;
						s_d.rsp_data = s_q.sb[hit_idx].data;
					end else begin
						s_d.ld_pend = 1'b1;
						s_d.ld_addr = cpu_req_addr;
					end
				end
				OP_STORE, OP_FLUSH, OP_ATOMIC: begin
					s_d.sb[s_d.sb_cnt[SB_IDX_W-1:0]] = '{
						valid: 1'b1,
						op: cpu_req_op,
						addr: cpu_req_addr,
						data: cpu_req_op == OP_FLUSH ? '0 : cpu_req_data,
						mask: cpu_req_op == OP_FLUSH ? '0 : cpu_req_mask,
						epoch: s_q.epoch
					};
					s_d.sb_cnt = s_d.sb_cnt + SB_CNT_W'(1);
					s_d.epoch_used = 1'b1;
					if (cpu_req_op == OP_FLUSH) begin
						s_d.lfl_valid = 1'b1;
						s_d.lfl_addr = cpu_req_addr;
					end
					if (cpu_req_op == OP_ATOMIC) begin
						s_d.atom = 1'b1;
					end
				end
				OP_BARRIER: begin
					// Empty partitions are skipped so epochs never alias
					if (s_q.mode && s_q.epoch_used) begin
						s_d.epoch = s_q.epoch + EPOCH_W'(1);
						s_d.epoch_used = 1'b0;
					end
				end
				OP_MODE: begin
					s_d.mode = cpu_req_data[0] & PSO_SUPPORTED;
				end
				default: begin
				end
			endcase
		end

		s_d.req_ready = !s_d.ld_pend && !s_d.atom &&
			s_d.sb_cnt < SB_FULL &&
			!(acc && cpu_req_op == OP_LOAD);
		s_d.fetch_ready = s_d.fst == FS_IDLE;
		s_d.rfl_ready = s_d.rfq_cnt < RFQ_FULL;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= ST_RST;
			s_q.mode <= MODE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign cpu_req_ready = s_q.req_ready;
	assign cpu_rsp_valid = s_q.rsp_valid;
	assign cpu_rsp_data = s_q.rsp_data;
	assign mode_pso = s_q.mode;
	assign fetch_ready = s_q.fetch_ready;
	assign fetch_rsp_valid = s_q.f_rsp_valid;
	assign fetch_rsp_data = s_q.f_rsp_data;
	assign mem_req_valid = s_q.mvalid;
	assign mem_req_kind = s_q.mkind;
	assign mem_req_addr = s_q.maddr;
	assign mem_req_data = s_q.mdata;
	assign mem_req_mask = s_q.mmask;
	assign rfl_in_ready = s_q.rfl_ready;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_TSO_HEAD: assert property (iss_drain && !s_q.mode |-> sel_idx == '0)
		else $error("out-of-order drain in total store order");
	AST_LOAD_FWD: assert property (acc && cpu_req_op == OP_LOAD && hit
		|=> cpu_rsp_valid && cpu_rsp_data == $past(s_q.sb[hit_idx].data))
		else $error("forwarded load did not answer next cycle");
	AST_LOAD_BLOCK: assert property (s_q.ld_pend |-> !cpu_req_ready)
		else $error("request accepted with load outstanding");
	AST_ATOM_ALONE: assert property (iss_drain &&
		s_q.sb[sel_idx].op == OP_ATOMIC |-> s_q.sb_cnt == SB_CNT_W'(1))
		else $error("atomic issued with buffer not drained");
	AST_PSO_EPOCH: assert property (iss_drain
		|-> s_q.sb[sel_idx].epoch == s_q.sb[0].epoch)
		else $error("drain crossed a store barrier");
	AST_SAME_LOC: assert property (iss_drain && sel_idx != '0
		|-> !same_dw(s_q.sb[0].addr, s_q.sb[sel_idx].addr))
		else $error("same-location entry overtook an older one");
	AST_NO_PSO: assert property (!PSO_SUPPORTED |-> !mode_pso)
		else $error("mode bit set without partial order support");
	AST_BAR_NOP: assert property (acc && cpu_req_op == OP_BARRIER && !s_q.mode
		|=> $stable(s_q.epoch))
		else $error("barrier acted in total store order");
	AST_LFL_NEXT: assert property (acc && cpu_req_op == OP_FLUSH
		|=> ib.inval_valid && ib.inval_addr == $past(cpu_req_addr))
		else $error("local flush not applied next cycle");
	AST_RFL_KIND: assert property (iss_drain && s_q.sb[sel_idx].op == OP_FLUSH
		|=> mem_req_valid && mem_req_kind == MK_RFLUSH)
		else $error("flush entry not sent as remote flush");
	AST_FULL_STALL: assert property (s_q.sb_cnt == SB_FULL |-> !cpu_req_ready)
		else $error("ready while store buffer full");
	AST_ONE_OP: assert property (mem_req_valid && !mem_req_ready
		|=> mem_req_valid && $stable(mem_req_addr))
		else $error("memory request dropped before acceptance");

	COV_PSO_REORDER: cover property (iss_drain && sel_idx != '0);
	COV_LOAD_HIT: cover property (acc && cpu_req_op == OP_LOAD && hit);
	COV_ATOMIC_DONE: cover property (s_q.atom ##1 !s_q.atom);
	COV_FETCH_MISS: cover property (s_q.fst == FS_MISS ##[1:20] fetch_rsp_valid);
endmodule // ssob_top

// File: tb/ssob_mem_model.sv
module ssob_mem_model
	import ssob_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic mem_req_valid,
	input wire ssob_mem_e mem_req_kind,
	input wire logic [ADDR_W-1:0] mem_req_addr,
	input wire logic [DATA_W-1:0] mem_req_data,
	input wire logic [MASK_W-1:0] mem_req_mask,
	output logic mem_req_ready,
	output logic mem_rsp_valid,
	output logic [DATA_W-1:0] mem_rsp_data
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [DATA_W-1:0] mem [logic [28:0]];
	logic [28:0] seen_q [$];
	int ifetch_cnt;
	int wait_cnt;
	logic busy;
	logic [DATA_W-1:0] old_v;
	logic [DATA_W-1:0] new_v;
	logic [28:0] dw;

	function automatic logic [DATA_W-1:0] rd(logic [28:0] a);
		return mem.exists(a) ? mem[a] : {a, 3'h5, ~a, 3'h2};
	endfunction

	// ------------------------------------------------------------
	// Single port: one operation at a time
	// ------------------------------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_req_ready <= 1'b0;
			mem_rsp_valid <= 1'b0;
			mem_rsp_data <= '0;
			busy <= 1'b0;
			ifetch_cnt = 0;
		end else begin
			mem_rsp_valid <= 1'b0;
			mem_rsp_data <= ~mem_rsp_data;
			if (busy) begin
				if (wait_cnt == 0) begin
					busy <= 1'b0;
					mem_rsp_valid <= 1'b1;
					mem_rsp_data <= old_v;
				end else
					wait_cnt--;
			end else if (mem_req_valid && mem_req_ready) begin
				mem_req_ready <= 1'b0;
				busy <= 1'b1;
				wait_cnt = slow ? $urandom_range(5, 0) : 0;
				dw = mem_req_addr[31:3];
				old_v = rd(dw);
				new_v = old_v;
				// Read and write of an atomic in one step
				for (int i = 0; i < MASK_W; i++) begin
					if (mem_req_mask[i])
						new_v[i*8 +: 8] = mem_req_data[i*8 +: 8];
				end
				// Remote flush leaves memory as it is
				if (mem_req_kind inside {MK_WRITE, MK_ATOMIC})
					mem[dw] = new_v;
				if (mem_req_kind inside {MK_WRITE, MK_ATOMIC, MK_RFLUSH})
					seen_q.push_back(dw);
				if (mem_req_kind == MK_IFETCH)
					ifetch_cnt++;
			end else
				mem_req_ready <= mem_req_valid && (!slow || $urandom_range(1, 0) == 1);
		end
	end
endmodule // ssob_mem_model

// File: tb/store_order_buffer_tb.sv
module store_order_buffer_tb
	import ssob_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys, rst_n, slow, cpu_req_valid, cpu_req_ready, cpu_rsp_valid;
	ssob_op_e cpu_req_op;
	logic [31:0] cpu_req_addr, fetch_addr, rfl_in_addr, mem_req_addr;
	logic [63:0] cpu_req_data, cpu_rsp_data, mem_req_data, mem_rsp_data;
	logic [7:0] cpu_req_mask, mem_req_mask;
	logic mode_pso, fetch_valid, fetch_ready, fetch_rsp_valid, mem_req_valid;
	logic [31:0] fetch_rsp_data;
	ssob_mem_e mem_req_kind;
	logic mem_req_ready, mem_rsp_valid, rfl_in_valid, rfl_in_ready;
	int error_cnt, checks_done, cyc, n;
	logic [63:0] ref_mem [logic [28:0]];
	logic [28:0] exp_q [$];

	ssob_top i_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .cpu_req_valid(cpu_req_valid),
		.cpu_req_op(cpu_req_op), .cpu_req_addr(cpu_req_addr),
		.cpu_req_data(cpu_req_data), .cpu_req_mask(cpu_req_mask),
		.cpu_req_ready(cpu_req_ready), .cpu_rsp_valid(cpu_rsp_valid),
		.cpu_rsp_data(cpu_rsp_data), .mode_pso(mode_pso),
		.fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
		.fetch_ready(fetch_ready), .fetch_rsp_valid(fetch_rsp_valid),
		.fetch_rsp_data(fetch_rsp_data), .mem_req_valid(mem_req_valid),
		.mem_req_kind(mem_req_kind), .mem_req_addr(mem_req_addr),
		.mem_req_data(mem_req_data), .mem_req_mask(mem_req_mask),
		.mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
		.mem_rsp_data(mem_rsp_data), .rfl_in_valid(rfl_in_valid),
		.rfl_in_addr(rfl_in_addr), .rfl_in_ready(rfl_in_ready)
	);

	ssob_mem_model i_mem (
		.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
		.mem_req_valid(mem_req_valid), .mem_req_kind(mem_req_kind),
		.mem_req_addr(mem_req_addr), .mem_req_data(mem_req_data),
		.mem_req_mask(mem_req_mask), .mem_req_ready(mem_req_ready),
		.mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data)
	);

	always #5 clk_sys = ~clk_sys;

	function automatic logic [63:0] ref_rd(logic [28:0] a);
		return ref_mem.exists(a) ? ref_mem[a] : {a, 3'h5, ~a, 3'h2};
	endfunction

	// ------------------------------------------------------------
	// Compare and report
	// ------------------------------------------------------------
	task automatic cmp_data(logic [63:0] got, logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_word(logic [31:0] got, logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end

	// ------------------------------------------------------------
	// Processor, fetch and order tasks
	// ------------------------------------------------------------
	task automatic cpu_op(ssob_op_e op, logic [31:0] a, logic [63:0] d);
		cpu_req_valid <= 1'b1;
		cpu_req_op <= op;
		cpu_req_addr <= a;
		cpu_req_data <= d;
		n = 0;
		do @(posedge clk_sys) n++; while (cpu_req_ready !== 1'b1 && n < 500);
		if (n >= 500)
			error_cnt++;
		if (op inside {OP_STORE, OP_FLUSH, OP_ATOMIC})
			exp_q.push_back(a[31:3]);
		if (op inside {OP_STORE, OP_ATOMIC})
			ref_mem[a[31:3]] = d;
	endtask

	task automatic cpu_rd(ssob_op_e op, logic [31:0] a, logic [63:0] d);
		logic [63:0] e;
		e = ref_rd(a[31:3]);
		cpu_op(op, a, d);
		cpu_req_valid <= 1'b0;
		n = 0;
		do @(posedge clk_sys) n++; while (cpu_rsp_valid !== 1'b1 && n < 500);
		cmp_data(cpu_rsp_data, e);
	endtask

	task automatic fetch(logic [31:0] a, int misses);
		logic [63:0] v;
		int c0;
		v = ref_rd(a[31:3]);
		c0 = i_mem.ifetch_cnt;
		fetch_valid <= 1'b1;
		fetch_addr <= a;
		n = 0;
		do @(posedge clk_sys) n++; while (fetch_ready !== 1'b1 && n < 500);
		fetch_valid <= 1'b0;
		do @(posedge clk_sys) n++; while (fetch_rsp_valid !== 1'b1 && n < 900);
		cmp_word(fetch_rsp_data, a[2] ? v[63:32] : v[31:0]);
		cmp_word(32'(i_mem.ifetch_cnt - c0), 32'(misses));
	endtask

	task automatic check_order();
		cmp_word(32'(i_mem.seen_q.size()), 32'(exp_q.size()));
		foreach (exp_q[i])
			cmp_word(32'(i_mem.seen_q[i]), 32'(exp_q[i]));
		i_mem.seen_q.delete();
		exp_q.delete();
	endtask

	task automatic run_rand(int cnt);
		int k;
		logic [31:0] a;
		for (int i = 0; i < cnt; i++) begin
			k = $urandom_range(5, 0);
			a = 32'h400 + 32'($urandom_range(31, 0));
			if (k == 2)
				cpu_rd(OP_LOAD, a, 64'h0);
			else if (k == 5)
				cpu_rd(OP_ATOMIC, a, {$urandom, $urandom});
			else if (k == 3)
				cpu_op(OP_FLUSH, a, 64'h0);
			else if (k == 4)
				cpu_op(OP_BARRIER, a, 64'h0);
			else
				cpu_op(OP_STORE, a, {$urandom, $urandom});
		end
		cpu_rd(OP_ATOMIC, 32'h400, 64'h0);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		rst_n = 1'b0;
		slow = 1'b0;
		cpu_req_valid = 1'b0;
		cpu_req_op = OP_LOAD;
		cpu_req_addr = '0;
		cpu_req_data = '0;
		cpu_req_mask = 8'hff;
		fetch_valid = 1'b0;
		fetch_addr = '0;
		rfl_in_valid = 1'b0;
		rfl_in_addr = '0;
		void'($urandom(11));
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		cmp_word({31'h0, mode_pso}, 32'h0);
		fetch(32'h100, 1);
		fetch(32'h104, 0);
		cpu_op(OP_STORE, 32'h100, 64'h1122334455667788);
		cpu_op(OP_FLUSH, 32'h100, 64'h0);
		cpu_rd(OP_ATOMIC, 32'h300, 64'h5);
		fetch(32'h104, 1);
		check_order();
		fetch(32'h208, 1);
		for (int i = 0; i < 5; i++) begin
			rfl_in_valid <= 1'b1;
			rfl_in_addr <= 32'h208 + 32'(i * 64);
			n = 0;
			do @(posedge clk_sys) n++; while (rfl_in_ready !== 1'b1 && n < 500);
		end
		rfl_in_valid <= 1'b0;
		repeat (8) @(posedge clk_sys);
		fetch(32'h20c, 1);
		cpu_op(OP_MODE, 32'h0, 64'h1);
		cpu_req_valid <= 1'b0;
		repeat (2) @(posedge clk_sys);
		cmp_word({31'h0, mode_pso}, 32'h1);
		slow <= 1'b1;
		exp_q.delete();
		i_mem.seen_q.delete();
		cpu_op(OP_STORE, 32'h500, 64'ha1);
		cpu_op(OP_STORE, 32'h508, 64'hb2);
		cpu_op(OP_STORE, 32'h504, 64'ha3);
		cpu_op(OP_BARRIER, 32'h0, 64'h0);
		cpu_op(OP_STORE, 32'h510, 64'hc4);
		cpu_rd(OP_ATOMIC, 32'h518, 64'hd5);
		cmp_data(i_mem.rd(29'h0a0), 64'ha3);
		cmp_word(32'(i_mem.seen_q[3]), 32'h0a2);
		run_rand(60);
		cpu_op(OP_MODE, 32'h0, 64'h0);
		cpu_req_valid <= 1'b0;
		@(posedge clk_sys);
		exp_q.delete();
		i_mem.seen_q.delete();
		run_rand(60);
		check_order();
		final_report();
	end
endmodule // store_order_buffer_tb
